// ===== core/smc_pkg.sv
package smc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CONTROL     = 8'h55;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h56;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'h57;

  // Control register field positions
  localparam int          LEVEL_MSB       = 7;
  localparam int          LEVEL_LSB       = 4;
  localparam int          RESET_EN_BIT    = 3;
  localparam int          ACTIVE_BIT      = 2;
  localparam int          CMP_LEVEL_BIT   = 1;
  localparam int          FLAG_BIT        = 0;

  // Threshold codes
  localparam logic [3:0]  LEVEL_OFF       = 4'h0;
  localparam logic [3:0]  LEVEL_EXTERNAL  = 4'hF;

  // Interrupt status and mask layout
  localparam int          IRQ_LOW_BIT     = 0;
  localparam int          IRQ_READY_BIT   = 1;
  localparam int          IRQ_W           = 2;

  // Reset values
  localparam logic [3:0]  LEVEL_RST       = 4'h0;
  localparam logic        RESET_EN_RST    = 1'b0;
  localparam logic        FLAG_RST        = 1'b0;
  localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;

  // Timing
  localparam int          CLK_MHZ         = 100;
  localparam int          SETTLE_US       = 50;
  localparam int          SETTLE_CYCLES   = SETTLE_US * CLK_MHZ;
  localparam int          HYST_CYCLES     = 16;

  typedef enum {
    SMC_OFF,
    SMC_SETTLE,
    SMC_ON
  } smc_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } smc_apb_req_t;

  typedef struct packed {
    logic        monitor_enable;
    logic        external_select;
    logic [3:0]  threshold_level_select;
  } smc_analog_ctrl_t;

endpackage

// ===== core/smc_top.sv
// Functional notes
// - Upper nibble selects threshold; zero keeps the supervisor off, non-zero turns it on.
// - Bit 2 reads whether the supervisor operates; writing it never turns it on.
// - Bit 1 mirrors the live comparator level without latching.
// - Bit 0 flag sets on low voltage and holds until software writes zero.
// - Register fields reset only by brownout reset, not by other resets.
// - Control register is one eight-bit read/write register at index 055h.
// - Every threshold comparison applies hysteresis against small supply changes.
// - With reset enable set, flag becoming set requests a power-on reset.
// - Threshold code all ones monitors the external input against internal reference.
// - Zero to non-zero level waits 50 us settling; a write ends it early.
// - Clearing the flag while low voltage persists has no effect; the flag stays set.
`timescale 1ns/1ps
module smc_top
  import smc_pkg::*;
#(
  parameter int SETTLE_CNT = SETTLE_CYCLES,
  parameter int HYST_CNT   = HYST_CYCLES
)(
  input  wire logic             ref_clk,         // 100 MHz clock
  input  wire logic             reset_n,         // Brownout reset, async, active low
  input  wire logic             clk_en,          // Freezes all state while low
  input  wire smc_apb_req_t     apb_req,         // APB request signals
  output logic                  pready,          // APB ready
  output logic [31:0]           prdata,          // APB read data
  output logic                  pslverr,         // APB error on unmapped address
  input  wire logic             cmp_supply_low,  // Supply comparator, high when below
  input  wire logic             cmp_ext_low,     // External input comparator, high when below
  output smc_analog_ctrl_t      analog_ctrl,     // Comparator enable and threshold
  output logic                  por_request,     // One-cycle power-on reset request
  output logic                  irq              // Level interrupt
);

  localparam int SCNT_W = $clog2(SETTLE_CNT + 1);
  localparam int HCNT_W = $clog2(HYST_CNT + 1);

  // Counters cannot serve a zero-length settle or release interval
  if (SETTLE_CNT < 1 || HYST_CNT < 1)
  begin : g_param_check
    $error("smc_top: SETTLE_CNT and HYST_CNT must be at least one");
  end

  // Register state
  logic [3:0]           threshold_level_select;
  logic                 low_voltage_reset_enable;
  logic                 low_voltage_flag;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;
  smc_state_t           state;
  logic [SCNT_W-1:0]    settle_cnt;

  // Comparator path
  logic                 sup_meta;
  logic                 sup_sync;
  logic                 ext_meta;
  logic                 ext_sync;
  logic                 comparator_output_level;
  logic                 low_cond;
  logic [HCNT_W-1:0]    hyst_cnt;

  // Bus decode
  logic                 access;
  logic                 done;
  logic                 wr_done;
  logic [7:0]           reg_idx;
  logic                 word_aligned;
  logic                 hit_ctl;
  logic                 hit_sts;
  logic                 hit_msk;
  logic                 mapped;
  logic                 wr_ctl;
  logic [3:0]           wr_level;

  // Events
  logic                 monitor_active_status;
  logic                 flag_set;
  logic                 settle_done;
  logic [IRQ_W-1:0]     irq_events;
  logic [7:0]           ctl_read;

  assign reg_idx      = apb_req.paddr[9:2];
  assign word_aligned = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0);
  assign hit_ctl      = word_aligned && (reg_idx == IDX_CONTROL);
  assign hit_sts      = word_aligned && (reg_idx == IDX_IRQ_STATUS);
  assign hit_msk      = word_aligned && (reg_idx == IDX_IRQ_MASK);
  assign mapped       = hit_ctl || hit_sts || hit_msk;
  assign access       = apb_req.psel && apb_req.penable;
  assign done         = access && pready;
  assign wr_done      = done && apb_req.pwrite && mapped;
  assign wr_ctl       = wr_done && hit_ctl;
  assign wr_level     = apb_req.pwdata[LEVEL_MSB:LEVEL_LSB];

  assign monitor_active_status = (state == SMC_ON);
  assign settle_done = (state == SMC_SETTLE) && (settle_cnt == SCNT_W'(SETTLE_CNT - 1))
                       && !wr_ctl;
  // Detection only counts once the supervisor is settled and running
  assign flag_set    = monitor_active_status && low_cond;

  assign irq_events[IRQ_LOW_BIT]   = flag_set && !low_voltage_flag;
  assign irq_events[IRQ_READY_BIT] = settle_done;

  assign ctl_read = {threshold_level_select,
                     low_voltage_reset_enable,
                     monitor_active_status,
                     comparator_output_level,
                     low_voltage_flag};

  // Asynchronous comparator outputs pass two flops before any use
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sup_meta <= 1'b0;
      sup_sync <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end
    else if (clk_en)
    begin
      sup_meta <= cmp_supply_low;
      sup_sync <= sup_meta;
      ext_meta <= cmp_ext_low;
      ext_sync <= ext_meta;
    end
  end

  // Live channel view; the external channel replaces the supply at code all ones
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      comparator_output_level <= 1'b0;
    else if (clk_en)
      comparator_output_level <= (threshold_level_select == LEVEL_EXTERNAL) ? ext_sync
                                                                             : sup_sync;
  end

  // Condition asserts at once but releases only after a quiet interval,
  // so supply ripple near the threshold cannot make it chatter
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_cond <= 1'b0;
      hyst_cnt <= '0;
    end
    else if (clk_en)
    begin
      if (comparator_output_level)
      begin
        low_cond <= 1'b1;
        hyst_cnt <= '0;
      end
      else if (low_cond)
      begin
        if (hyst_cnt == HCNT_W'(HYST_CNT - 1))
        begin
          low_cond <= 1'b0;
          hyst_cnt <= '0;
        end
        else
          hyst_cnt <= hyst_cnt + 1'b1;
      end
    end
  end

  // Control fields; only the brownout reset returns them to initial values
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      threshold_level_select   <= LEVEL_RST;
      low_voltage_reset_enable <= RESET_EN_RST;
    end
    else if (clk_en && wr_ctl)
    begin
      threshold_level_select   <= wr_level;
      low_voltage_reset_enable <= apb_req.pwdata[RESET_EN_BIT];
      // Bits 2 and 1 of the write data are not stored anywhere
    end
  end

  // Supervisor sequencing
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= SMC_OFF;
      settle_cnt <= '0;
    end
    else if (clk_en)
    begin
      unique case (state)
        SMC_OFF:
        begin
          settle_cnt <= '0;
          if (wr_ctl && wr_level != LEVEL_OFF)
            state <= SMC_SETTLE;
        end
        SMC_SETTLE:
        begin
          if (wr_ctl && wr_level == LEVEL_OFF)
            state <= SMC_OFF;
          else if (wr_ctl || settle_done)
            state <= SMC_ON;
          settle_cnt <= settle_cnt + 1'b1;
        end
        SMC_ON:
        begin
          // Level to level changes get no automatic delay
          if (wr_ctl && wr_level == LEVEL_OFF)
            state <= SMC_OFF;
        end
      endcase
    end
  end

  // Sticky flag; hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      low_voltage_flag <= FLAG_RST;
    else if (clk_en)
    begin
      if (flag_set)
        low_voltage_flag <= 1'b1;
      else if (wr_ctl)
        low_voltage_flag <= apb_req.pwdata[FLAG_BIT];
    end
  end

  // Reset request fires on the cycle the flag goes from clear to set
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      por_request <= 1'b0;
    else if (clk_en)
      por_request <= low_voltage_reset_enable && flag_set && !low_voltage_flag;
  end

  // Analog control outputs
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      analog_ctrl <= '0;
    else if (clk_en)
    begin
      analog_ctrl.monitor_enable         <= (threshold_level_select != LEVEL_OFF);
      analog_ctrl.external_select        <= (threshold_level_select == LEVEL_EXTERNAL);
      analog_ctrl.threshold_level_select <= threshold_level_select;
    end
  end

  // Interrupt status: event set wins over write-one-to-clear
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_status <= '0;
    else if (clk_en)
    begin
      if (wr_done && hit_sts)
        irq_status <= (irq_status & ~apb_req.pwdata[IRQ_W-1:0]) | irq_events;
      else
        irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_mask <= IRQ_MASK_RST;
    else if (clk_en && wr_done && hit_msk)
      irq_mask <= apb_req.pwdata[IRQ_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else if (clk_en)
      irq <= |(irq_status & irq_mask);
  end

  // APB slave: one wait state, answer on the second access cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped;
    end
  end

  // Read data is captured with the ready edge so it matches the answer cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= '0;
    else if (clk_en)
    begin
      if (access && !pready && !apb_req.pwrite)
      begin
        if (hit_ctl)
          prdata <= {24'h000000, ctl_read};
        else if (hit_sts)
          prdata <= {{(32-IRQ_W){1'b0}}, irq_status};
        else if (hit_msk)
          prdata <= {{(32-IRQ_W){1'b0}}, irq_mask};
        else
          prdata <= '0;
      end
      else
        prdata <= '0;
    end
  end

endmodule // smc_top

// ===== dv/smc_cmp_model.sv
`timescale 1ns/1ps
module smc_cmp_model
  import smc_pkg::*;
(
  input  wire smc_analog_ctrl_t analog_ctrl,    // Enable and threshold from the block
  input  wire logic             supply_low,     // Supply below chosen level
  input  wire logic             ext_low,        // External input below reference
  output logic                  cmp_supply_low, // Supply comparator output
  output logic                  cmp_ext_low     // External comparator output
);
  // A disabled comparator draws no current and reads low
  assign cmp_supply_low = analog_ctrl.monitor_enable & ~analog_ctrl.external_select
                          & supply_low;
  assign cmp_ext_low    = analog_ctrl.monitor_enable & analog_ctrl.external_select
                          & ext_low;
endmodule // smc_cmp_model

// ===== dv/smc_top_asserts.sv
`timescale 1ns/1ps
module smc_top_asserts
  import smc_pkg::*;
#(
  parameter int SETTLE_CNT = SETTLE_CYCLES,
  parameter int HYST_CNT   = HYST_CYCLES
)(
  input wire logic             ref_clk,        // Clock
  input wire logic             reset_n,        // Brownout reset
  input wire logic             clk_en,         // Clock enable
  input wire smc_apb_req_t     apb_req,        // Bus request
  input wire logic             pready,         // Bus ready
  input wire logic [31:0]      prdata,         // Read data
  input wire logic             pslverr,        // Bus error
  input wire logic             cmp_supply_low, // Supply comparator
  input wire logic             cmp_ext_low,    // External comparator
  input wire smc_analog_ctrl_t analog_ctrl,    // Comparator control
  input wire logic             por_request,    // Reset request
  input wire logic             irq             // Interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !clk_en);
  logic [3:0] wr_level;
  wire wr_done = apb_req.psel & apb_req.penable & apb_req.pwrite & pready
                 & (apb_req.paddr == 12'h154);
  always_ff @(posedge ref_clk)
  begin
    if (wr_done)
      wr_level <= apb_req.pwdata[7:4];
  end
  a_level_copy: assert property (wr_done |-> ##2
    analog_ctrl.threshold_level_select == wr_level)
    else $error("threshold select does not follow the written level");
  a_enable_level: assert property (analog_ctrl.monitor_enable ==
    (analog_ctrl.threshold_level_select != LEVEL_OFF))
    else $error("monitor enable disagrees with level");
  a_ext_select: assert property (analog_ctrl.external_select ==
    (analog_ctrl.threshold_level_select == LEVEL_EXTERNAL))
    else $error("external select disagrees with level");
  a_ready_wait: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unaligned: assert property (pready && apb_req.paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  a_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  a_por_enabled: assert property (por_request |-> $past(analog_ctrl.monitor_enable))
    else $error("reset request while monitor off");
endmodule // smc_top_asserts

bind smc_top smc_top_asserts #(.SETTLE_CNT(SETTLE_CNT), .HYST_CNT(HYST_CNT)) chk_u (
  .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .apb_req(apb_req),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .cmp_supply_low(cmp_supply_low),
  .cmp_ext_low(cmp_ext_low), .analog_ctrl(analog_ctrl), .por_request(por_request), .irq(irq));

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import smc_pkg::*;
  typedef struct packed
  {
    logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;
  } smc_row_t;
  localparam int SETTLE = 20;
  logic             ref_clk, reset_n, supply_low, ext_low, pready, pslverr, por_request, irq;
  logic             cmp_supply_low, cmp_ext_low, e, clk_en;
  logic [31:0]      prdata, q;
  smc_apb_req_t     req;
  smc_analog_ctrl_t actl;
  int               num_errors, tests_run, cycles, por_seen;
  smc_row_t rows[8] = '{'{0, 12'h154, 0, 0, 0}, '{1, 12'h154, 32'h06, 0, 0},
    '{0, 12'h154, 0, 0, 0}, '{0, 12'h155, 0, 0, 1}, '{1, 12'h400, 32'h1, 0, 1},
    '{0, 12'h160, 0, 0, 1}, '{1, 12'h15C, 32'h3, 0, 0}, '{0, 12'h15C, 0, 32'h3, 0}};
  smc_top #(.SETTLE_CNT(SETTLE), .HYST_CNT(4)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .clk_en(clk_en), .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cmp_supply_low(cmp_supply_low), .cmp_ext_low(cmp_ext_low), .analog_ctrl(actl),
    .por_request(por_request), .irq(irq));
  smc_cmp_model cmp_u (.analog_ctrl(actl), .supply_low(supply_low), .ext_low(ext_low),
    .cmp_supply_low(cmp_supply_low), .cmp_ext_low(cmp_ext_low));
  initial
  begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    por_seen += (por_request === 1'b1);
    // Whole run needs well under a thousand cycles
    if (cycles == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel    <= 1'b1;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    req.penable <= 1'b0;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // No answer time is assumed; only the bench timeout ends this wait
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_data(q, exp);
  endtask
  initial
  begin
    reset_n = 0;
    req = '0;
    supply_low = 0;
    ext_low = 0;
    clk_en = 1;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk_data(q, rows[i].q);
      chk_flag(e, rows[i].e);
    end
    apb(1'b1, 12'h154, 32'h10);
    rd(12'h154, 32'h10);
    // Frozen clock enable must hold the settling count where it stands
    clk_en <= 1'b0;
    repeat (SETTLE + 5) @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(12'h154, 32'h10);
    repeat (SETTLE + 5) @(posedge ref_clk);
    rd(12'h154, 32'h14);
    chk_flag(irq, 1'b1);
    apb(1'b1, 12'h158, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk_flag(irq, 1'b0);
    apb(1'b1, 12'h154, 32'h0);
    apb(1'b1, 12'h154, 32'h20);
    apb(1'b1, 12'h154, 32'h28);
    rd(12'h154, 32'h2C);
    supply_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(12'h154, 32'h2F);
    chk_flag(por_seen == 1, 1'b1);
    apb(1'b1, 12'h154, 32'h2C);
    rd(12'h154, 32'h2F);
    supply_low <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rd(12'h154, 32'h2D);
    chk_flag(por_seen == 1, 1'b1);
    apb(1'b1, 12'h154, 32'hF0);
    ext_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(12'h154, 32'hF7);
    chk_flag(por_seen == 1, 1'b1);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    ext_low <= 1'b0;
    @(posedge ref_clk);
    rd(12'h154, 32'h0);
    wrap_up();
  end
endmodule // testbench
